// >>> design/uclkg_pkg.sv
// package: constants and types for the usart clock generator
package uclkg_pkg;
  localparam int unsigned DIV_W          = 12;
  localparam logic [11:0] DIV_RESET      = 12'h000;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  // control register field positions
  localparam int unsigned CTRL_SYNC_BIT  = 0;
  localparam int unsigned CTRL_DBL_BIT   = 1;
  localparam int unsigned CTRL_POL_BIT   = 2;
  localparam int unsigned CTRL_DIR_BIT   = 3;
  localparam int unsigned CTRL_PWR_BIT   = 4;
  // register offsets on the software port
  localparam logic [1:0]  ADDR_CTRL      = 2'h0;
  localparam logic [1:0]  ADDR_DIV_LOW   = 2'h1;
  localparam logic [1:0]  ADDR_DIV_HIGH  = 2'h2;
  localparam logic [1:0]  ADDR_STATUS    = 2'h3;
  // per-bit last state index, one less than the state count (transmit divider and receive sample states)
  localparam logic [3:0]  STATES_NORMAL  = 4'hf;
  localparam logic [3:0]  STATES_DOUBLE  = 4'h7;
  localparam logic [3:0]  STATES_SYNC    = 4'h1;
  localparam logic [11:0] PEER_HALF_RESET = 12'h004;
  typedef enum logic [1:0]
  {
    UCLKG_ASYNC_NORMAL = 2'b00,
    UCLKG_ASYNC_DOUBLE = 2'b01,
    UCLKG_SYNC_MASTER  = 2'b10,
    UCLKG_SYNC_SLAVE   = 2'b11
  } uclkg_mode_t;
endpackage

// >>> design/uclkg_link_if.sv
// interface: transfer clock and data lines between device and peer
`timescale 1ns/1ps
interface uclkg_link_if;
  logic dev_xck_out;
  logic dev_xck_oe_n;
  logic peer_xck_out;
  logic peer_xck_oe_n;
  logic dev_txd;
  logic peer_txd;
  logic xck;
  // device drives when its enable is low, else the peer, else idle high
  assign xck = !dev_xck_oe_n ? dev_xck_out : (!peer_xck_oe_n ? peer_xck_out : 1'b1);
  modport device
  (
    input  xck,
    output dev_xck_out,
    output dev_xck_oe_n,
    output dev_txd,
    input  peer_txd
  );
  modport peer
  (
    input  xck,
    output peer_xck_out,
    output peer_xck_oe_n,
    output peer_txd,
    input  dev_txd
  );
endinterface

// >>> design/uclkg_device.sv
// device end: usart clock generation unit with software register port
// Function
// [RULE1] four clock modes, sync select chooses synchronous
// [RULE2] in sync, pin direction picks master/slave
// [RULE3] transfer clock pin used only in sync
// [RULE4] down-counter reloads at zero or low write
// [RULE5] baud tick each time counter hits zero
// [RULE6] tx divides baud by 16, 8, 2
// [RULE7] rx takes baud directly, 16/8/2 states
// [RULE8] 12-bit divisor from separate high/low writes
// [RULE9] software keeps double speed clear in sync
// [RULE10] double speed receiver uses 8 samples
// [RULE11] slave clock synchronised then edge detected
// [RULE12] peer slave clock below quarter system clock
// [RULE13] sample on edge opposite to change edge
// [RULE14] polarity zero: change rising, sample falling
// [RULE15] power reduction bit set disables unit
// [RULE16] internal generator except in sync slave
// [RULE17] master drives clock out, slave takes in
// [RULE18] clocks are single-cycle enables, one domain
`timescale 1ns/1ps
module uclkg_device
  import uclkg_pkg::*;
(
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  // software register port
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // clock enables toward transmitter and receiver
  output logic            o_tx_clk_en,
  output logic            o_tx_change_en,
  output logic            o_rx_clk_en,
  output logic            o_rx_sample_en,
  // transmit data from the shifter toward the line, and the received bit back to it
  input  wire logic       i_tx_bit,
  output logic            o_rx_bit,
  // link
  uclkg_link_if.device    link
);
  logic [7:0]  ctrl;
  logic [7:0]  next_ctrl;
  logic [11:0] divisor;
  logic [11:0] next_divisor;
  logic [11:0] count;
  logic [11:0] next_count;
  logic        baud_tick;
  logic        next_baud_tick;
  logic [3:0]  tx_div;
  logic [3:0]  next_tx_div;
  logic [3:0]  rx_state;
  logic [3:0]  next_rx_state;
  logic        xck_out;
  logic        next_xck_out;
  logic        xck_s1;
  logic        xck_s2;
  logic        xck_prev;
  logic        rxd_s1;
  logic        rxd_s2;
  logic        tx_pulse;
  logic        next_tx_pulse;
  logic        tx_chg;
  logic        next_tx_chg;
  logic        rx_pulse;
  logic        next_rx_pulse;
  logic        rx_samp;
  logic        next_rx_samp;
  logic [7:0]  rdata;
  logic [7:0]  next_rdata;
  logic        txd;
  logic        next_txd;
  logic        rxbit;
  logic        next_rxbit;
  logic        oe_n;
  logic        next_oe_n;
  uclkg_mode_t mode;
  logic [3:0]  last_state;
  logic        enabled;
  logic        rise;
  logic        fall;
  logic        change_edge;
  logic        sample_edge;

  always_comb
  begin
    enabled = !ctrl[CTRL_PWR_BIT]; // RULE15
    if (!ctrl[CTRL_SYNC_BIT]) // RULE1
      mode = ctrl[CTRL_DBL_BIT] ? UCLKG_ASYNC_DOUBLE : UCLKG_ASYNC_NORMAL;
    else if (ctrl[CTRL_DIR_BIT]) // RULE2
      mode = UCLKG_SYNC_MASTER;
    else
      mode = UCLKG_SYNC_SLAVE;
    case (mode)
      UCLKG_ASYNC_NORMAL: last_state = STATES_NORMAL; // RULE6
      UCLKG_ASYNC_DOUBLE: last_state = STATES_DOUBLE; // RULE10
      UCLKG_SYNC_MASTER:  last_state = STATES_SYNC;
      default:            last_state = STATES_SYNC;
    endcase
    // edge detector reads the second stage and its delayed copy xck_prev
    rise = xck_s2 && !xck_prev; // RULE11
    fall = !xck_s2 && xck_prev;
    change_edge = ctrl[CTRL_POL_BIT] ? fall : rise; // RULE14
    sample_edge = ctrl[CTRL_POL_BIT] ? rise : fall; // RULE13
  end

  // register port and baud generator
  always_comb
  begin
    next_ctrl = ctrl;
    next_divisor = divisor;
    next_rdata = 8'h00;
    if (i_wr && i_addr == ADDR_CTRL)
      next_ctrl = i_wdata;
    if (i_wr && i_addr == ADDR_DIV_LOW)
      next_divisor[7:0] = i_wdata; // RULE8
    if (i_wr && i_addr == ADDR_DIV_HIGH)
      next_divisor[11:8] = i_wdata[3:0];
    if (i_rd)
    begin
      case (i_addr)
        ADDR_CTRL:     next_rdata = ctrl;
        ADDR_DIV_LOW:  next_rdata = divisor[7:0];
        ADDR_DIV_HIGH: next_rdata = {4'h0, divisor[11:8]};
        ADDR_STATUS:   next_rdata = {2'h0, xck_s2, rxd_s2, rx_state};
        default:       next_rdata = 8'h00;
      endcase
    end
    next_baud_tick = 1'b0;
    if (!enabled)
      next_count = next_divisor;
    else if (i_wr && i_addr == ADDR_DIV_LOW)
      next_count = next_divisor; // RULE4
    else if (count == 12'h000)
    begin
      next_count = divisor; // RULE4
      next_baud_tick = 1'b1; // RULE5
    end
    else
      next_count = count - 12'h001;
  end

  // per-bit dividers and the pin drive
  always_comb
  begin
    next_tx_div = tx_div;
    next_rx_state = rx_state;
    // hold the idle level outside master so the first toggle is a change edge
    next_xck_out = (mode == UCLKG_SYNC_MASTER) ? xck_out : ctrl[CTRL_POL_BIT];
    next_tx_pulse = 1'b0;
    next_tx_chg = 1'b0;
    next_rx_pulse = 1'b0;
    next_rx_samp = 1'b0;
    next_oe_n = !(enabled && mode == UCLKG_SYNC_MASTER); // RULE17
    next_txd = enabled ? txd : 1'b1;
    next_rxbit = rxbit;
    if (!enabled)
    begin
      next_tx_div = 4'h0;
      next_rx_state = 4'h0;
      next_xck_out = ctrl[CTRL_POL_BIT];
    end
    else if (mode == UCLKG_SYNC_SLAVE) // RULE16
    begin
      next_tx_pulse = change_edge; // RULE18
      next_tx_chg = change_edge;
      next_rx_pulse = sample_edge;
      next_rx_samp = sample_edge;
      if (change_edge)
        next_txd = i_tx_bit;
      if (sample_edge)
        next_rxbit = rxd_s2;
    end
    else if (baud_tick) // RULE16
    begin
      next_rx_pulse = 1'b1; // RULE7
      next_rx_state = (rx_state >= last_state) ? 4'h0 : rx_state + 4'h1; // RULE7
      if (tx_div >= last_state) // RULE6
      begin
        next_tx_div = 4'h0;
        next_tx_pulse = 1'b1;
      end
      else
        next_tx_div = tx_div + 4'h1;
      if (mode == UCLKG_SYNC_MASTER) // RULE3
      begin
        // idle level equals polarity, first toggle is the change edge
        next_xck_out = !xck_out;
        if (xck_out == ctrl[CTRL_POL_BIT])
        begin
          next_tx_chg = 1'b1; // RULE14
          next_txd = i_tx_bit;
        end
        else
        begin
          next_rx_samp = 1'b1; // RULE13
          next_rxbit = rxd_s2;
        end
      end
      else
      begin
        next_txd = (tx_div >= last_state) ? i_tx_bit : txd;
        // async: sample near the middle of the bit
        if (rx_state == {1'b0, last_state[3:1]})
        begin
          next_rx_samp = 1'b1;
          next_rxbit = rxd_s2;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl <= CTRL_RESET;
      divisor <= DIV_RESET;
      count <= DIV_RESET;
      baud_tick <= 1'b0;
      tx_div <= 4'h0;
      rx_state <= 4'h0;
      xck_out <= 1'b0;
      // sync stages start at the idle pin level, no false edge after reset
      xck_s1 <= 1'b1;
      xck_s2 <= 1'b1;
      xck_prev <= 1'b1;
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      tx_pulse <= 1'b0;
      tx_chg <= 1'b0;
      rx_pulse <= 1'b0;
      rx_samp <= 1'b0;
      rdata <= 8'h00;
      txd <= 1'b1;
      rxbit <= 1'b1;
      oe_n <= 1'b1;
    end
    else
    begin
      ctrl <= next_ctrl;
      divisor <= next_divisor;
      count <= next_count;
      baud_tick <= next_baud_tick;
      tx_div <= next_tx_div;
      rx_state <= next_rx_state;
      xck_out <= next_xck_out;
      xck_s1 <= link.xck; // RULE11
      xck_s2 <= xck_s1;
      xck_prev <= xck_s2;
      rxd_s1 <= link.peer_txd;
      rxd_s2 <= rxd_s1;
      tx_pulse <= next_tx_pulse;
      tx_chg <= next_tx_chg;
      rx_pulse <= next_rx_pulse;
      rx_samp <= next_rx_samp;
      rdata <= next_rdata;
      txd <= next_txd;
      rxbit <= next_rxbit;
      oe_n <= next_oe_n;
    end
  end

  assign o_rdata = rdata;
  assign o_tx_clk_en = tx_pulse;
  assign o_tx_change_en = tx_chg;
  assign o_rx_clk_en = rx_pulse;
  assign o_rx_sample_en = rx_samp;
  assign o_rx_bit = rxbit;
  assign link.dev_xck_out = xck_out;
  assign link.dev_xck_oe_n = oe_n;
  assign link.dev_txd = txd;
endmodule

// >>> design/uclkg_peer.sv
// peer end: remote synchronous transceiver sharing clock and data lines
`timescale 1ns/1ps
module uclkg_peer
  import uclkg_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // user side
  input  wire logic        i_master,
  input  wire logic        i_polarity,
  input  wire logic [11:0] i_half_period,
  input  wire logic        i_tx_bit,
  output logic             o_rx_bit,
  output logic             o_rx_valid,
  output logic             o_tx_taken,
  // link
  uclkg_link_if.peer       link
);
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic        clk_out;
  logic        next_clk_out;
  logic        oe_n;
  logic        next_oe_n;
  logic        txd;
  logic        next_txd;
  logic        rxbit;
  logic        next_rxbit;
  logic        rx_valid;
  logic        next_rx_valid;
  logic        taken;
  logic        next_taken;
  logic        xck_s1;
  logic        xck_s2;
  logic        xck_prev;
  logic        rxd_s1;
  logic        rxd_s2;
  logic        rise;
  logic        fall;
  logic        chg;
  logic        smp;

  always_comb
  begin
    rise = xck_s2 && !xck_prev;
    fall = !xck_s2 && xck_prev;
    chg = i_polarity ? fall : rise; // RULE14
    smp = i_polarity ? rise : fall; // RULE13
    next_cnt = cnt;
    next_clk_out = clk_out;
    next_oe_n = !i_master;
    next_txd = txd;
    next_rxbit = rxbit;
    next_rx_valid = 1'b0;
    next_taken = 1'b0;
    if (!i_master)
    begin
      next_cnt = 12'h000;
      next_clk_out = i_polarity;
    end
    // floor of four gives halves of five cycles, under a quarter rate
    else if (cnt >= ((i_half_period < PEER_HALF_RESET) ? PEER_HALF_RESET : i_half_period)) // RULE12
    begin
      next_cnt = 12'h000;
      next_clk_out = !clk_out;
    end
    else
      next_cnt = cnt + 12'h001;
    if (chg)
    begin
      next_txd = i_tx_bit;
      next_taken = 1'b1;
    end
    if (smp)
    begin
      next_rxbit = rxd_s2;
      next_rx_valid = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt <= 12'h000;
      clk_out <= 1'b0;
      oe_n <= 1'b1;
      txd <= 1'b1;
      rxbit <= 1'b1;
      rx_valid <= 1'b0;
      taken <= 1'b0;
      // sync stages start at the idle pin level, no false edge after reset
      xck_s1 <= 1'b1;
      xck_s2 <= 1'b1;
      xck_prev <= 1'b1;
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
    end
    else
    begin
      cnt <= next_cnt;
      clk_out <= next_clk_out;
      oe_n <= next_oe_n;
      txd <= next_txd;
      rxbit <= next_rxbit;
      rx_valid <= next_rx_valid;
      taken <= next_taken;
      xck_s1 <= link.xck;
      xck_s2 <= xck_s1;
      xck_prev <= xck_s2;
      rxd_s1 <= link.dev_txd;
      rxd_s2 <= rxd_s1;
    end
  end

  assign o_rx_bit = rxbit;
  assign o_rx_valid = rx_valid;
  assign o_tx_taken = taken;
  assign link.peer_xck_out = clk_out;
  assign link.peer_xck_oe_n = oe_n;
  assign link.peer_txd = txd;
endmodule

// >>> bench/uclkg_sva.sv
// checker: relations on the transfer clock and data lines of the link
`timescale 1ns/1ps
module uclkg_sva
(
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // link lines
  input  wire logic dev_xck_out,
  input  wire logic dev_xck_oe_n,
  input  wire logic peer_xck_out,
  input  wire logic peer_xck_oe_n,
  input  wire logic dev_txd,
  input  wire logic peer_txd,
  input  wire logic xck
);
  logic        prev_out;
  logic        tog;
  logic [12:0] hcnt;
  logic [12:0] hlast;
  logic [1:0]  ntog;
  logic [12:0] next_hcnt;
  logic [12:0] next_hlast;
  logic [1:0]  next_ntog;

  default clocking dcb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  // half-period length of the master clock; cleared whenever the pin is released
  always_comb
  begin
    tog        = !dev_xck_oe_n && (dev_xck_out != prev_out);
    next_hcnt  = dev_xck_oe_n ? 13'h0000 : (tog ? 13'h0001 : hcnt + 13'h0001);
    next_hlast = tog ? hcnt : hlast;
    next_ntog  = dev_xck_oe_n ? 2'h0 : ((tog && ntog != 2'h3) ? ntog + 2'h1 : ntog);
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      prev_out <= 1'b0;
      hcnt     <= 13'h0000;
      hlast    <= 13'h0000;
      ntog     <= 2'h0;
    end
    else
    begin
      prev_out <= dev_xck_out;
      hcnt     <= next_hcnt;
      hlast    <= next_hlast;
      ntog     <= next_ntog;
    end
  end

  sequence dev_tog;
    $changed(dev_xck_out) && !dev_xck_oe_n && !$past(dev_xck_oe_n);
  endsequence
  sequence peer_tog;
    $changed(peer_xck_out) && !peer_xck_oe_n && !$past(peer_xck_oe_n);
  endsequence
  sequence dev_chg;
    $changed(dev_txd) && !dev_xck_oe_n && !$past(dev_xck_oe_n);
  endsequence
  sequence peer_chg;
    $changed(peer_txd) && !peer_xck_oe_n && !$past(peer_xck_oe_n) && !$past(peer_xck_oe_n, 4);
  endsequence

  one_driver_a: assert property (!peer_xck_oe_n |-> dev_xck_oe_n)
    else $error("device drives the clock pin while the peer does");
  master_half_a: assert property (dev_tog |=> $stable(dev_xck_out))
    else $error("master clock half shorter than two cycles");
  half_equal_a: assert property (tog && ntog >= 2'h2 |-> hcnt == hlast)
    else $error("master clock halves differ");
  half_bound_a: assert property (hcnt <= 13'h1000)
    else $error("master clock half beyond the largest divisor");
  dev_change_a: assert property (dev_chg |-> $changed(dev_xck_out) || $past(dev_xck_out) != $past(dev_xck_out, 2))
    else $error("master data changed away from a clock edge");
  slave_delay_a: assert property ($changed(dev_txd) && !peer_xck_oe_n && dev_xck_oe_n |->
    $past(xck, 2) != $past(xck, 3) || $past(xck, 3) != $past(xck, 4) || $past(xck, 4) != $past(xck, 5))
    else $error("slave data change not tied to a synchronised clock edge");
  peer_half_a: assert property (peer_tog |=> $stable(peer_xck_out)[*4])
    else $error("peer clock half shorter than five cycles");
  peer_change_a: assert property (peer_chg |-> $past(peer_xck_out, 3) != $past(peer_xck_out, 4))
    else $error("peer data changed away from its clock edge");
endmodule

// >>> bench/test_usart_clock_generator.sv
// testbench: device and peer ends joined over the link
`timescale 1ns/1ps
module test_usart_clock_generator
  import uclkg_pkg::*;
;
  localparam logic [11:0] PH = 12'h005;
  logic       ref_clk, rstn, wr, rd, dtx, ptx, pmst, pol, pdtx, pptx;
  logic [1:0] addr;
  logic [7:0] wdata, rdata;
  logic       txe, tce, rxe, rse, drx, prx, pval, ptk;
  logic [31:0] rs;
  int         n_mismatch, check_count, cyc, ltx, lrx, nb, pb;
  bit         txv, rxv, lnk, da, pa, quiet, rdd;
  logic [7:0] rdq[$];
  int         txq[$], rxq[$];
  logic       dq[$], pq[$];

  uclkg_link_if lk ();
  uclkg_device u_uclkg_device
  (
    .i_ref_clk(ref_clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_tx_clk_en(txe), .o_tx_change_en(tce), .o_rx_clk_en(rxe), .o_rx_sample_en(rse),
    .i_tx_bit(dtx), .o_rx_bit(drx), .link(lk)
  );
  uclkg_peer u_uclkg_peer
  (
    .i_ref_clk(ref_clk), .i_rstn(rstn), .i_master(pmst), .i_polarity(pol), .i_half_period(PH),
    .i_tx_bit(ptx), .o_rx_bit(prx), .o_rx_valid(pval), .o_tx_taken(ptk), .link(lk)
  );
  uclkg_sva u_uclkg_sva
  (
    .i_ref_clk(ref_clk), .i_rstn(rstn), .dev_xck_out(lk.dev_xck_out), .dev_xck_oe_n(lk.dev_xck_oe_n),
    .peer_xck_out(lk.peer_xck_out), .peer_xck_oe_n(lk.peer_xck_oe_n), .dev_txd(lk.dev_txd),
    .peer_txd(lk.peer_txd), .xck(lk.xck)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic report(input string what);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, what);
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) report($sformatf("read %h want %h", got, exp));
  endtask
  task automatic cmpn(input int got, input int exp);
    check_count++;
    if (got != exp) report($sformatf("interval %0d want %0d", got, exp));
  endtask
  task automatic cmpb(input logic got, input logic exp);
    check_count++;
    if (got !== exp) report($sformatf("bit %b want %b", got, exp));
  endtask

  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask
  task automatic rreg(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    rdq.push_back(e);
    @(posedge ref_clk);
    rd   <= 1'b0;
  endtask

  // the first pulse after arming only sets the time base, so a mode switch transient is never measured
  task automatic arm(input int t, input int r);
    @(negedge ref_clk);
    txv = 1'b0;
    rxv = 1'b0;
    repeat (2) txq.push_back(t);
    repeat (2) rxq.push_back(r);
    wait (txq.size() == 0 && rxq.size() == 0);
  endtask
  task automatic mode(input logic [7:0] c, input logic [7:0] hi, input logic [7:0] lo);
    int d;
    int k;
    d = {hi[3:0], lo};
    k = c[CTRL_SYNC_BIT] ? 2 : (c[CTRL_DBL_BIT] ? 8 : 16);
    wreg(ADDR_DIV_HIGH, hi);
    wreg(ADDR_DIV_LOW, lo);
    wreg(ADDR_CTRL, c);
    rreg(ADDR_CTRL, c);
    rreg(ADDR_DIV_LOW, lo);
    rreg(ADDR_DIV_HIGH, {4'h0, hi[3:0]});
    arm(k * (d + 1), d + 1);
  endtask
  task automatic sync(input logic p, input logic m);
    @(posedge ref_clk);
    pol <= p;
    if (m)
      mode(8'h09 | {5'h00, p, 2'h0}, 8'h00, 8'h07);
    else
    begin
      wreg(ADDR_CTRL, 8'h01 | {5'h00, p, 2'h0});
      pmst <= 1'b1;
      repeat (30) @(posedge ref_clk);
      arm(2 * (int'(PH) + 1), 2 * (int'(PH) + 1));
    end
    @(negedge ref_clk);
    lnk = 1'b1;
    wait (nb >= 10 && pb >= 10);
    @(negedge ref_clk);
    lnk = 1'b0;
    da  = 1'b0;
    pa  = 1'b0;
    nb  = 0;
    pb  = 0;
    dq.delete();
    pq.delete();
    @(posedge ref_clk);
    pmst <= 1'b0;
    repeat (20) @(posedge ref_clk);
  endtask

  // monitor: read data, pulse intervals and bits across the link, each against its oldest note
  always @(posedge ref_clk)
  begin
    cyc++;
    if (rdd) cmp8(rdata, rdq.pop_front());
    rdd = rd;
    if (quiet && (txe || rxe || tce || rse)) cmpn(1, 0);
    if (txe && txq.size() != 0)
    begin
      if (txv) cmpn(cyc - ltx, txq.pop_front());
      txv = 1'b1;
    end
    if (rxe && rxq.size() != 0)
    begin
      if (rxv) cmpn(cyc - lrx, rxq.pop_front());
      rxv = 1'b1;
    end
    if (txe) ltx = cyc;
    if (rxe) lrx = cyc;
    if (lnk)
    begin
      if (da && lk.dev_txd !== pdtx) cmpb(lk.xck, ~pol);
      if (da && lk.dev_txd !== pdtx) cmpb(tce, 1'b1);
      if (pa && lk.peer_txd !== pptx) cmpb(lk.xck, ~pol);
      if (pa && lk.peer_txd !== pptx) cmpb(ptk, 1'b1);
      if (pval)
      begin
        if (da) cmpb(prx, dq.pop_front());
        da = 1'b1;
        nb++;
        rs = lfsr(rs);
        dtx <= rs[0];
        dq.push_back(rs[0]);
      end
      if (rse)
      begin
        if (pa) cmpb(drx, pq.pop_front());
        pa = 1'b1;
        pb++;
        rs = lfsr(rs);
        ptx <= rs[0];
        pq.push_back(rs[0]);
      end
    end
    pdtx = lk.dev_txd;
    pptx = lk.peer_txd;
  end

  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    final_report();
  end

  initial
  begin
    {rstn, wr, rd, dtx, ptx, pmst, pol, addr, wdata} = '0;
    rs = 32'h2384;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    rreg(ADDR_CTRL, CTRL_RESET);
    rreg(ADDR_DIV_HIGH, 8'h00);
    mode(8'h00, 8'h00, 8'h00);
    wreg(ADDR_CTRL, 8'h10);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    quiet = 1'b1;
    rreg(ADDR_STATUS, 8'h30);
    repeat (60) @(posedge ref_clk);
    @(negedge ref_clk);
    quiet = 1'b0;
    mode(8'h00, 8'hf0, 8'h03);
    mode(8'h02, 8'h01, 8'h00);
    for (int p = 0; p < 2; p++)
      for (int m = 0; m < 2; m++)
        sync(p[0], m[0]);
    final_report();
  end
endmodule
